// ===== ssp_defines.svh
// Purpose: constants of the synchronous serial port
// Assumes: register index times four gives the byte address
// Notes: indices above 6'h18 hold the interrupt registers
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// register indices
`define SSP_IDX_STATUS 6'h10
`define SSP_IDX_CONTROL 6'h12
`define SSP_IDX_TX0 6'h14
`define SSP_IDX_TX1 6'h16
`define SSP_IDX_RX 6'h18
`define SSP_IDX_IRQ_STAT 6'h1a
`define SSP_IDX_IRQ_CLR 6'h1b
`define SSP_IDX_IRQ_EN 6'h1c

// control fields
`define SSP_CTL_DE0 0
`define SSP_CTL_DE1 1
`define SSP_CTL_DIV_LO 4
`define SSP_CTL_DIV_HI 5

// status fields
`define SSP_STS_BUSY 0
`define SSP_STS_DONE 1
`define SSP_STS_ERR 2

// interrupt fields
`define SSP_IRQ_DONE 0
`define SSP_IRQ_ERR 1

// reset values
`define SSP_CTL_RST 16'h0000
`define SSP_STS_RST 16'h0000
`define SSP_BYTE_RST 8'h00

// timing: index of the last bit of a byte
`define SSP_LAST_BIT 3'h7

`endif

// ===== ssp_periph_model.sv
// Purpose: behavioural serial peripheral on the far side of the port
// Assumes: the device drives data and clock; one shared data wire
// Notes: reports each transmitted byte with its measured clock period
`timescale 1ns/100ps
module ssp_periph_model (
  // clock
  input wire logic clk,
  // serial link
  input wire logic serial_clock,
  input wire logic serial_data_pin_out,
  input wire logic serial_data_pin_oe,
  input wire logic peripheral_enable_zero,
  input wire logic peripheral_enable_one,
  output logic serial_data_pin_in,
  // test side
  input wire logic [7:0] reply_byte,
  output logic got_byte,
  output logic [15:0] got_data
);
  logic sclk_q = 1'b0;
  logic bit_q = 1'b0;
  logic [2:0] cnt_q = 3'h0;
  logic [7:0] sh_q = 8'h00;
  logic [7:0] pc_q = 8'h00;
  logic sel;

  assign sel = peripheral_enable_zero | peripheral_enable_one;
  // the device wins the wire while it drives
  assign serial_data_pin_in = serial_data_pin_oe ? serial_data_pin_out : bit_q;
  initial begin
    got_byte = 1'b0;
    got_data = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // follow serial clock
  always @(posedge clk) begin
    sclk_q <= serial_clock;
    pc_q <= pc_q + 8'h01;
    got_byte <= 1'b0;
    if (!sel) begin
      // released line toggles so a stale level never looks valid
      cnt_q <= 3'h0;
      bit_q <= ~bit_q;
    end else if (serial_clock && !sclk_q) begin
      cnt_q <= cnt_q + 3'h1;
      pc_q <= 8'h01;
      sh_q <= {serial_data_pin_out, sh_q[7:1]};
      if (cnt_q == 3'h7 && serial_data_pin_oe) begin
        got_byte <= 1'b1;
        got_data <= {serial_data_pin_out, sh_q[7:1], pc_q};
      end
    end else if ((sclk_q && !serial_clock) || cnt_q == 3'h0) begin
      bit_q <= reply_byte[cnt_q];
    end
  end
endmodule

// ===== ssp_pkg.sv
// Purpose: types of the synchronous serial port
// Assumes: nothing beyond the defines header
// Notes: state of the top and of the synchroniser is one packed struct each
package ssp_pkg;

  typedef enum logic [1:0] {
    ssp_ph_idle = 2'b00,
    ssp_ph_lo = 2'b01,
    ssp_ph_hi = 2'b10
  } ssp_phase_t;

  typedef struct packed {
    logic [1:0] de;
    logic [1:0] div;
    logic [7:0] tx0;
    logic [7:0] tx1;
    logic [7:0] rx;
    logic [7:0] shreg;
    logic done;
    logic err;
    logic rx_mode;
    logic [2:0] bitcnt;
    logic [3:0] divcnt;
    ssp_phase_t phase;
    logic sclk;
    logic sdo;
    logic sdoe;
    logic en0;
    logic en1;
    logic [1:0] ista;
    logic [1:0] ien;
    logic irq;
    logic waitreq;
    logic [15:0] rdata;
    logic rd_done_cap;
  } ssp_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } ssp_sync_t;

endpackage

// ===== ssp_sync3.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: din is asynchronous to clk
// Notes: output changes only once stages two and three agree
`timescale 1ns/100ps
module ssp_sync3 (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // data
  input wire logic din,
  output logic dout
);

  ssp_pkg::ssp_sync_t s_q;
  ssp_pkg::ssp_sync_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.s1 = din;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    if (s_q.s2 == s_q.s3) begin
      s_d.out = s_q.s3;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.out;

endmodule

// ===== ssp_top.sv
// Purpose: synchronous serial port with Avalon-MM register access
// Assumes: one clock; the peripheral drives data on the falling edge
// Notes: bytes move least significant bit first, so bit 7 is last
//
// Contract
// - received byte lands in receive register low byte
// - two transmit registers hold bytes to send
// - control resets zero; enable bits drive outputs
// - both enables set drives only output zero
// - divide field selects clock by 2,4,8,16
// - receive read or transmit write while busy sets the error flag
// - error flag clears while both enables zero
// - done flag sets at bit seven rising edge
// - rx read, tx write, disable clear done
// - status read clears done if it returned done set; set wins
// - busy flag high during any transfer
// - status read-only, upper bits zero, resets zero
`timescale 1ns/100ps
`include "ssp_defines.svh"
module ssp_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // serial link
  output logic serial_clock,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  output logic peripheral_enable_zero,
  output logic peripheral_enable_one,
  // interrupt
  output logic irq
);

  generate
    if (ADDR_W < 8) begin : g_bad_addr
      $error("ADDR_W must be at least 8");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [5:0] idx);
    hit = (a[7:2] == idx) && (a[1:0] == 2'b00) &&
          ((a >> 8) == '0);
  endfunction

  // half period of the serial clock minus one, in processor clocks
  function automatic logic [3:0] half_reload(input logic [1:0] div);
    case (div)
      2'b00: half_reload = 4'h0;
      2'b01: half_reload = 4'h1;
      2'b10: half_reload = 4'h3;
      default: half_reload = 4'h7;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  ssp_pkg::ssp_state_t s_q;
  ssp_pkg::ssp_state_t s_d;
  logic sdi;
  logic req;
  logic acc;
  logic busy;
  logic rd_sts;
  logic rd_rx;
  logic wr_tx0;
  logic wr_tx1;
  logic wr_tx;
  logic wr_ctl;
  logic de_zero;
  logic ev_done;
  logic ev_err;
  logic start_tx;
  logic start_rx;

  // the filter adds four clocks of latency, so at divide by 2 the
  // peripheral must drive early enough for the rising edge sample
  ssp_sync3 u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din(serial_data_pin_in),
    .dout(sdi)
  );

  always_comb begin
    s_d = s_q;
    req = avs_read | avs_write;
    acc = req & ~s_q.waitreq;
    busy = s_q.phase != ssp_pkg::ssp_ph_idle;
    rd_sts = acc & avs_read & hit(avs_address, `SSP_IDX_STATUS);
    rd_rx = acc & avs_read & hit(avs_address, `SSP_IDX_RX);
    wr_tx0 = acc & avs_write & avs_byteenable[0] &
             hit(avs_address, `SSP_IDX_TX0);
    wr_tx1 = acc & avs_write & avs_byteenable[0] &
             hit(avs_address, `SSP_IDX_TX1);
    wr_tx = wr_tx0 | wr_tx1;
    wr_ctl = acc & avs_write & avs_byteenable[0] &
             hit(avs_address, `SSP_IDX_CONTROL);
    de_zero = s_q.de == 2'b00;
    ev_done = 1'b0;
    ev_err = busy & (rd_rx | wr_tx);
    start_tx = wr_tx & ~busy & ~de_zero;
    start_rx = rd_rx & ~busy & ~de_zero;

    //////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, data captured before acceptance
    s_d.waitreq = 1'b1;
    if (req & s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      s_d.rdata = 16'h0000;
      s_d.rd_done_cap = s_q.done;
      if (avs_read) begin
        if (hit(avs_address, `SSP_IDX_STATUS)) begin
          s_d.rdata[`SSP_STS_BUSY] = busy;
          s_d.rdata[`SSP_STS_DONE] = s_q.done;
          s_d.rdata[`SSP_STS_ERR] = s_q.err;
        end else if (hit(avs_address, `SSP_IDX_CONTROL)) begin
          s_d.rdata[`SSP_CTL_DE1:`SSP_CTL_DE0] = s_q.de;
          s_d.rdata[`SSP_CTL_DIV_HI:`SSP_CTL_DIV_LO] = s_q.div;
        end else if (hit(avs_address, `SSP_IDX_TX0)) begin
          s_d.rdata[7:0] = s_q.tx0;
        end else if (hit(avs_address, `SSP_IDX_TX1)) begin
          s_d.rdata[7:0] = s_q.tx1;
        end else if (hit(avs_address, `SSP_IDX_RX)) begin
          s_d.rdata[7:0] = s_q.rx;
        end else if (hit(avs_address, `SSP_IDX_IRQ_STAT)) begin
          s_d.rdata[1:0] = s_q.ista;
        end else if (hit(avs_address, `SSP_IDX_IRQ_EN)) begin
          s_d.rdata[1:0] = s_q.ien;
        end
      end
    end

    //////////////////////////////////////////////////////////////////////
    // register writes
    if (wr_ctl) begin
      s_d.de = avs_writedata[`SSP_CTL_DE1:`SSP_CTL_DE0];
      s_d.div = avs_writedata[`SSP_CTL_DIV_HI:`SSP_CTL_DIV_LO];
    end
    // transmit holding registers; ignored while busy
    if (wr_tx0 & ~busy) begin
      s_d.tx0 = avs_writedata[7:0];
    end
    if (wr_tx1 & ~busy) begin
      s_d.tx1 = avs_writedata[7:0];
    end
    if (acc & avs_write & avs_byteenable[0] &
        hit(avs_address, `SSP_IDX_IRQ_EN)) begin
      s_d.ien = avs_writedata[1:0];
    end

    //////////////////////////////////////////////////////////////////////
    // shift engine
    case (s_q.phase)
      ssp_pkg::ssp_ph_idle: begin
        s_d.sclk = 1'b0;
        if (start_tx | start_rx) begin
          s_d.phase = ssp_pkg::ssp_ph_lo;
          s_d.bitcnt = 3'h0;
          s_d.divcnt = half_reload(s_q.div);
          s_d.rx_mode = start_rx;
          s_d.sdoe = start_tx;
          s_d.shreg = wr_tx0 ? avs_writedata[7:0] : s_q.tx1;
          if (wr_tx1) begin
            s_d.shreg = avs_writedata[7:0];
          end
          s_d.sdo = s_d.shreg[0];
        end
      end
      ssp_pkg::ssp_ph_lo: begin
        if (s_q.divcnt != 4'h0) begin
          s_d.divcnt = s_q.divcnt - 4'h1;
        end else begin
          s_d.sclk = 1'b1;
          s_d.phase = ssp_pkg::ssp_ph_hi;
          s_d.divcnt = half_reload(s_q.div);
          if (s_q.rx_mode) begin
            s_d.shreg = {sdi, s_q.shreg[7:1]};
          end
          if (s_q.bitcnt == `SSP_LAST_BIT) begin
            ev_done = 1'b1;
            if (s_q.rx_mode) begin
              s_d.rx = {sdi, s_q.shreg[7:1]};
            end
          end
        end
      end
      ssp_pkg::ssp_ph_hi: begin
        if (s_q.divcnt != 4'h0) begin
          s_d.divcnt = s_q.divcnt - 4'h1;
        end else begin
          s_d.sclk = 1'b0;
          s_d.divcnt = half_reload(s_q.div);
          if (s_q.bitcnt == `SSP_LAST_BIT) begin
            s_d.phase = ssp_pkg::ssp_ph_idle;
            s_d.sdoe = 1'b0;
          end else begin
            s_d.phase = ssp_pkg::ssp_ph_lo;
            s_d.bitcnt = s_q.bitcnt + 3'h1;
            if (!s_q.rx_mode) begin
              s_d.shreg = {1'b0, s_q.shreg[7:1]};
              s_d.sdo = s_q.shreg[1];
            end
          end
        end
      end
      default: begin
        s_d.phase = ssp_pkg::ssp_ph_idle;
      end
    endcase

    // disabling both selects aborts the byte in flight
    if (wr_ctl && s_d.de == 2'b00 && busy) begin
      s_d.phase = ssp_pkg::ssp_ph_idle;
      s_d.sclk = 1'b0;
      s_d.sdoe = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////
    // status flags: clear first, then set so that the set wins
    // done clears
    if (rd_rx | wr_tx | de_zero) begin
      s_d.done = 1'b0;
    end
    // status read clears what it showed
    if (rd_sts & s_q.rd_done_cap) begin
      s_d.done = 1'b0;
    end
    if (ev_done) begin
      s_d.done = 1'b1;
    end
    if (de_zero) begin
      s_d.err = 1'b0;
    end
    if (ev_err) begin
      s_d.err = 1'b1;
    end

    // interrupt status: write one to clear, events win
    if (acc & avs_write & avs_byteenable[0] &
        hit(avs_address, `SSP_IDX_IRQ_CLR)) begin
      s_d.ista = s_q.ista & ~avs_writedata[1:0];
    end
    s_d.ista[`SSP_IRQ_DONE] = s_d.ista[`SSP_IRQ_DONE] | ev_done;
    s_d.ista[`SSP_IRQ_ERR] = s_d.ista[`SSP_IRQ_ERR] | ev_err;
    s_d.irq = |(s_d.ista & s_d.ien);

    s_d.en0 = s_d.de[`SSP_CTL_DE0];
    s_d.en1 = s_d.de[`SSP_CTL_DE1] & ~s_d.de[`SSP_CTL_DE0];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.waitreq <= 1'b1;
      s_q.phase <= ssp_pkg::ssp_ph_idle;
      s_q.tx0 <= `SSP_BYTE_RST;
      s_q.tx1 <= `SSP_BYTE_RST;
      s_q.rx <= `SSP_BYTE_RST;
      s_q.rdata <= `SSP_STS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign avs_readdata = {16'h0000, s_q.rdata};
  assign avs_waitrequest = s_q.waitreq;
  assign serial_clock = s_q.sclk;
  assign serial_data_pin_out = s_q.sdo;
  assign serial_data_pin_oe = s_q.sdoe;
  assign peripheral_enable_zero = s_q.en0;
  assign peripheral_enable_one = s_q.en1;
  assign irq = s_q.irq;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_en_priority: assert property (
    (s_q.de == 2'b11) |-> (peripheral_enable_zero && !peripheral_enable_one))
    else $error("both enables set must drive only enable zero");

  a_en_follow: assert property (
    $changed(s_q.de) |-> (peripheral_enable_zero == s_q.de[0]))
    else $error("enable zero does not follow control");

  a_err_set: assert property (
    ev_err |=> s_q.err)
    else $error("access while busy did not set error");

  a_err_clear: assert property (
    (de_zero && !ev_err) |=> !s_q.err)
    else $error("error flag not cleared while disabled");

  a_done_rise: assert property (
    (s_q.phase == ssp_pkg::ssp_ph_lo && s_q.divcnt == 4'h0 &&
     s_q.bitcnt == 3'h7) |=> (s_q.done && serial_clock))
    else $error("done not set at last rising edge");

  a_done_rxclr: assert property (
    (rd_rx && !ev_done) |=> !s_q.done)
    else $error("receive read did not clear done");

  a_done_wins: assert property (
    (rd_sts && ev_done) |=> s_q.done)
    else $error("status read lost a same-cycle done");

  a_busy_hold: assert property (
    (start_tx && !wr_ctl) |=> busy [*8])
    else $error("transfer busy shorter than expected");

  a_div_two: assert property (
    ($rose(serial_clock) && s_q.div == 2'b00 && s_q.bitcnt != 3'h7 &&
     !wr_ctl) |=> !serial_clock ##1 serial_clock)
    else $error("divide by two clock period wrong");

  a_sts_upper: assert property (
    (!s_q.waitreq && avs_read && hit(avs_address, `SSP_IDX_STATUS))
    |-> (avs_readdata[31:3] == 29'h0))
    else $error("status reserved bits not zero");

  a_busy_idle: assert property (
    (busy && s_q.phase == ssp_pkg::ssp_ph_hi && s_q.divcnt == 4'h0 &&
     s_q.bitcnt == 3'h7) |=> !busy)
    else $error("busy not released after last bit");

  c_tx_done: cover property (
    s_q.sdoe && ev_done);
  c_rx_done: cover property (
    s_q.rx_mode && ev_done);
  c_err: cover property (
    ev_err);
  c_set_wins: cover property (
    rd_sts && ev_done);

endmodule

// ===== tb.sv
// Purpose: self-checking bench of the synchronous serial port
// Assumes: one wait cycle per bus access, fixed transfer length
// Notes: reads and serial bytes are checked from queues of notes
`timescale 1ns/100ps
module tb;
  logic clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address, reply_byte, b;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic serial_clock, sdi, sdo, sdoe, en0, en1, irq, got_byte;
  logic [15:0] got_data;
  logic [63:0] rq[$];
  logic [31:0] sq[$];
  logic [63:0] rexp;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed;
  int d;

  ssp_top #(.ADDR_W(8)) ssp_top_inst (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_clock(serial_clock), .serial_data_pin_in(sdi),
    .serial_data_pin_out(sdo), .serial_data_pin_oe(sdoe),
    .peripheral_enable_zero(en0), .peripheral_enable_one(en1), .irq(irq));

  ssp_periph_model ssp_periph_model_inst (
    .clk(clk), .serial_clock(serial_clock), .serial_data_pin_out(sdo),
    .serial_data_pin_oe(sdoe), .peripheral_enable_zero(en0),
    .peripheral_enable_one(en1), .serial_data_pin_in(sdi),
    .reply_byte(reply_byte), .got_byte(got_byte), .got_data(got_data));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    // a note never matched by a result counts as a miss
    n_fail += sq.size() + rq.size();
    $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] dt, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= dt;
    avs_byteenable <= be;
    avs_read <= ~w;
    avs_write <= w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    bus(1'b1, a, dt, 4'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    rq.push_back({m, e});
    bus(1'b0, a, 32'h0, 4'h0);
  endtask

  // pins as {irq, enable one, enable zero}, looked at mid-cycle
  task automatic pins(input logic [2:0] e);
    @(negedge clk);
    chk({29'h0, irq, en1, en0}, {29'h0, e});
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      rexp = rq.pop_front();
      chk(avs_readdata & rexp[63:32], rexp[31:0] & rexp[63:32]);
    end
    if (got_byte === 1'b1)
      chk({16'h0, got_data}, sq.pop_front());
  end

  // the whole run needs about six hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 5593;
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    reply_byte = 8'h00;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(8'h40, 4'h0, '1);
    rd(8'h48, 4'h0, '1);
    bus(1'b1, 8'h48, 4'h2, 4'hE);
    bus(1'b1, 8'h7C, 8'hFF, 4'hF);
    rd(8'h48, 4'h0, '1);
    rd(8'h7C, 4'h0, '1);
    wr(8'h70, 4'h0);
    for (d = 0; d < 4; d++) begin
      wr(8'h48, 32'(d));
      rd(8'h48, 32'(d), '1);
      pins({1'b0, d == 2, d[0]});
    end
    for (d = 0; d < 4; d++) begin
      wr(8'h48, 32'(d * 16 + 1 + d % 2));
      b = 8'($random(seed));
      sq.push_back({16'h0, b, 8'h02 << d});
      wr(d[0] ? 8'h58 : 8'h50, {24'h0, b});
      rd(8'h40, 4'h1, '1);
      // status read accepted in the cycle of the eighth rise
      if (d == 0) begin
        repeat (9) @(posedge clk);
        rd(8'h40, 4'h1, '1);
      end
      if (d == 3) begin
        wr(8'h58, {24'h0, ~b});
        rd(8'h40, 4'h5, '1);
      end
      repeat (16 << d) @(posedge clk);
      rd(8'h40, d == 3 ? 4'h6 : 4'h2, '1);
      rd(d[0] ? 8'h58 : 8'h50, {24'h0, b}, '1);
      if (d == 3)
        wr(8'h48, 8'h30);
      rd(8'h40, 4'h0, '1);
    end
    reply_byte <= 8'($random(seed));
    wr(8'h48, 8'h31);
    rd(8'h60, 4'h0, '0);
    repeat (136) @(posedge clk);
    rd(8'h40, 4'h2, '1);
    rd(8'h60, {24'h0, reply_byte}, '1);
    rd(8'h40, 4'h1, '1);
    rd(8'h60, {24'h0, reply_byte}, '1);
    rd(8'h40, 4'h5, '1);
    wr(8'h48, 8'h30);
    rd(8'h40, 4'h0, '1);
    pins(3'b000);
    rd(8'h68, 4'h3, '1);
    wr(8'h70, 4'h2);
    pins(3'b100);
    rd(8'h70, 4'h2, '1);
    wr(8'h6C, 4'h2);
    pins(3'b000);
    rd(8'h68, 4'h1, '1);
    wr(8'h70, 4'h1);
    pins(3'b100);
    wr(8'h6C, 4'h1);
    pins(3'b000);
    rd(8'h6C, 4'h0, '1);
    repeat (4) @(posedge clk);
    report_and_stop();
  end
endmodule
